//--- txsa_consts.svh
`ifndef TXSA_CONSTS_SVH
`define TXSA_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TXSA_OFS_RX_CLEAR      16'h3000
`define TXSA_OFS_RX_GOOD_LO    16'h3008
`define TXSA_OFS_RX_GOOD_HI    16'h300c
`define TXSA_OFS_INS_CTRL      16'h4800
`define TXSA_OFS_ADDR_LOW      16'h4804
`define TXSA_OFS_ADDR_HIGH     16'h4808
`define TXSA_OFS_LEN_LIMIT     16'h6004
`define TXSA_OFS_TX_CLEAR      16'h7000
`define TXSA_OFS_TX_GOOD_LO    16'h7008
`define TXSA_OFS_TX_GOOD_HI    16'h700c
`define TXSA_OFS_IRQ_STATUS    16'h7100
`define TXSA_OFS_IRQ_MASK      16'h7104

// ****************************************************************
// field positions and widths
// ****************************************************************
`define TXSA_BIT_ENABLE        0
`define TXSA_BIT_CLEAR         0
`define TXSA_ADDR_HIGH_W       16
`define TXSA_LEN_W             16
`define TXSA_CNT_W             36
`define TXSA_CNT_LO_W          32
`define TXSA_ERR_CLIENT        0
`define TXSA_ERR_OVERSIZE      1
`define TXSA_IRQ_W             3
`define TXSA_IRQ_TX_DONE       0
`define TXSA_IRQ_TX_OVERSIZE   1
`define TXSA_IRQ_RX_ERROR      2
`define TXSA_BEAT_BYTES        17'h00008

// ****************************************************************
// reset values
// ****************************************************************
`define TXSA_RST_LEN_LIMIT     16'h05ee
`define TXSA_RST_ZERO32        32'h0000_0000

`endif

//--- txsa_insert.sv
`timescale 1ns/100ps
`default_nettype none
module txsa_insert (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  enable,
  input  wire logic [47:0]           addr,
  input  wire txsa_pkg::txsa_beat_type in_beat,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  output txsa_pkg::txsa_beat_type    out_beat,
  output logic                       out_valid,
  input  wire logic                  out_ready
);
  import txsa_pkg::*;

  txsa_pos_type  pos_reg;
  txsa_pos_type  pos_next;
  txsa_beat_type beat_reg;
  txsa_beat_type beat_next;
  logic          valid_reg;
  logic          valid_next;
  logic          accept;

  // one register stage; ready only reaches back when the stage drains
  assign in_ready  = ~valid_reg | out_ready;
  assign accept    = in_valid & in_ready;
  assign out_beat  = beat_reg;
  assign out_valid = valid_reg;

  always_comb begin
    pos_next   = pos_reg;
    beat_next  = beat_reg;
    valid_next = valid_reg & ~out_ready;
    if (accept) begin
      valid_next = 1'b1;
      beat_next  = in_beat;
      // a disabled insert leaves bytes 6..11 untouched
      if (enable && in_beat.sop) begin                            // R3
        beat_next.data[15:0] = addr[47:32];                       // R3
      end else if (enable && pos_reg == TXSA_HDR1) begin          // R3
        beat_next.data[63:32] = addr[31:0];                       // R3
      end                                                         // R2
      if (in_beat.eop) begin
        pos_next = TXSA_HDR0;
      end else if (in_beat.sop) begin
        pos_next = TXSA_HDR1;
      end else if (pos_reg == TXSA_HDR1) begin
        pos_next = TXSA_PAYLOAD;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg   <= TXSA_HDR0;
      beat_reg  <= '0;
      valid_reg <= 1'b0;
    end else begin
      pos_reg   <= pos_next;
      beat_reg  <= beat_next;
      valid_reg <= valid_next;
    end
  end

endmodule : txsa_insert
`default_nettype wire

//--- txsa_partner.sv
`timescale 1ns/100ps
`default_nettype none
module txsa_partner (
  input wire logic pclk,
  input wire logic stall,
  input wire txsa_pkg::txsa_beat_type beat,
  input wire logic valid,
  output logic ready
);
  import txsa_pkg::*;
  // phy-side sink; when stalling it accepts one cycle in four
  txsa_beat_type got [$];
  logic [1:0] ph = 2'h0;
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    if (valid && ready) got.push_back(beat);
  end
  assign ready = !stall || (ph == 2'h3);
endmodule : txsa_partner
`default_nettype wire

//--- txsa_pkg.sv
package txsa_pkg;

  // one 64-bit stream beat, first byte of the frame in bits 63:56
  typedef struct packed {
    logic [63:0] data;
    logic        sop;
    logic        eop;
    logic [2:0]  empty;
    logic        error;
  } txsa_beat_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] error;
  } txsa_status_type;

  typedef enum logic [2:0] {
    TXSA_HDR0    = 3'b001,
    TXSA_HDR1    = 3'b010,
    TXSA_PAYLOAD = 3'b100
  } txsa_pos_type;

endpackage : txsa_pkg

//--- txsa_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "txsa_consts.svh"
module txsa_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire txsa_pkg::txsa_beat_type tx_in_beat,
  input wire logic tx_in_valid,
  input wire logic tx_in_ready,
  input wire txsa_pkg::txsa_beat_type tx_out_beat,
  input wire logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire txsa_pkg::txsa_status_type tx_frame_status_error,
  input wire logic rx_status_valid,
  input wire logic rx_status_error,
  input wire logic irq
);
  import txsa_pkg::*;
  // ****************************************
  // shadow of the insertion setup
  // ****************************************
  logic en_reg;
  logic second_reg;
  logic [47:0] addr_reg;
  wire wr = psel && penable && pwrite && pready;
  wire take = tx_in_valid && tx_in_ready;
  wire leave_eop = tx_out_valid && tx_out_ready && tx_out_beat.eop;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      second_reg <= 1'b0;
      addr_reg <= 48'h0;
    end else begin
      if (wr && paddr == `TXSA_OFS_INS_CTRL) en_reg <= pwdata[0];
      if (wr && paddr == `TXSA_OFS_ADDR_LOW) addr_reg[31:0] <= pwdata;
      if (wr && paddr == `TXSA_OFS_ADDR_HIGH) addr_reg[47:32] <= pwdata[15:0];
      // only the beat right after a multi-beat sop carries the low word
      if (take) second_reg <= tx_in_beat.sop && !tx_in_beat.eop;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pass; take && !en_reg |=> tx_out_beat == $past(tx_in_beat); endproperty
  a_pass: assert property (p_pass) else $error("beat altered with insertion off");
  property p_ins_hi;
    take && en_reg && tx_in_beat.sop |=> tx_out_beat.data == {$past(tx_in_beat.data[63:16]), addr_reg[47:32]};
  endproperty
  a_ins_hi: assert property (p_ins_hi) else $error("first address bytes wrong");
  property p_ins_lo;
    take && en_reg && second_reg && !tx_in_beat.sop |=> tx_out_beat.data == {addr_reg[31:0], $past(tx_in_beat.data[31:0])};
  endproperty
  a_ins_lo: assert property (p_ins_lo) else $error("last address bytes wrong");
  property p_taken; take |=> tx_out_valid; endproperty
  a_taken: assert property (p_taken) else $error("taken beat not forwarded");
  property p_hold; tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_beat); endproperty
  a_hold: assert property (p_hold) else $error("stalled beat dropped or changed");
  property p_stat_cause; tx_frame_status_error.valid |-> $past(leave_eop); endproperty
  a_stat_cause: assert property (p_stat_cause) else $error("status without frame end");
  property p_stat_each; leave_eop |=> tx_frame_status_error.valid; endproperty
  a_stat_each: assert property (p_stat_each) else $error("frame end without status");
  property p_mapped;
    psel && penable && (paddr == `TXSA_OFS_INS_CTRL || paddr == `TXSA_OFS_TX_CLEAR) |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on a mapped register");
  c_ins: cover property (take && en_reg && tx_in_beat.sop);
  c_over: cover property (tx_frame_status_error.valid && tx_frame_status_error.error[1]);
  c_irq: cover property (irq);
endmodule : txsa_properties
`default_nettype wire

//--- txsa_top.sv
// Contract
// R1: bit 0 of insert control enables source-address overwrite; bits 1..31 unused.
// R2: with enable 0 (reset value) the source address passes unchanged.
// R3: with enable 1 the source address becomes the programmed 6-byte address.
// R4: low word holds last four bytes; high register bits 15:0 the first two.
// R5: 16-bit length limit, reset 1518, used as the frame-length bound.
// R6: frames longer than the limit raise status error bit 1, counted oversized; no oversize counter here, such frames only skip the good count.
// R7: the length limit never truncates or blocks transmission.
// R8: writing 1 to receive clear bit 0 zeroes receive counters.
// R9: writing 1 to transmit clear bit 0 zeroes transmit counters.
// R10: separate read-only 36-bit good-frame counters for receive and transmit.
// R11: each counter reads as low word bits 31:0, next word bits 35:32.
// R12: clear bits return to 0 by themselves once the clear is done.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "txsa_consts.svh"
module txsa_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [15:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire txsa_pkg::txsa_beat_type tx_in_beat,
  input  wire logic                    tx_in_valid,
  output logic                         tx_in_ready,
  output txsa_pkg::txsa_beat_type      tx_out_beat,
  output logic                         tx_out_valid,
  input  wire logic                    tx_out_ready,
  output txsa_pkg::txsa_status_type    tx_frame_status_error,
  input  wire logic                    rx_status_valid,
  input  wire logic                    rx_status_error,
  output logic                         irq
);
  import txsa_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic                          ins_en_reg,     ins_en_next;
  logic [31:0]                   addr_low_reg,   addr_low_next;
  logic [`TXSA_ADDR_HIGH_W-1:0]  addr_high_reg,  addr_high_next;
  logic [`TXSA_LEN_W-1:0]        len_limit_reg,  len_limit_next;
  logic                          rx_clr_reg,     rx_clr_next;
  logic                          tx_clr_reg,     tx_clr_next;
  logic [`TXSA_CNT_W-1:0]        rx_good_reg,    rx_good_next;
  logic [`TXSA_CNT_W-1:0]        tx_good_reg,    tx_good_next;
  logic [16:0]                   len_acc_reg,    len_acc_next;
  txsa_status_type               status_reg,     status_next;
  logic [`TXSA_IRQ_W-1:0]        irq_stat_reg,   irq_stat_next;
  logic [`TXSA_IRQ_W-1:0]        irq_mask_reg,   irq_mask_next;
  logic [31:0]                   rdata_reg,      rdata_next;
  logic                          err_reg,        err_next;
  logic                          irq_reg,        irq_next;

  logic                          setup;
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          mapped;
  logic [31:0]                   rd_mux;
  logic                          out_fire;
  logic [16:0]                   beat_bytes;
  logic [16:0]                   frame_len;
  logic                          oversize;
  logic [`TXSA_IRQ_W-1:0]        irq_event;

  // ****************************************************************
  // transmit datapath with source-address insertion
  // ****************************************************************
  txsa_insert u_insert (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (ins_en_reg),
    .addr      ({addr_high_reg, addr_low_reg}),
    .in_beat   (tx_in_beat),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_beat  (tx_out_beat),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready)
  );

  // ****************************************************************
  // apb slave: zero wait states, read data registered in setup
  // ****************************************************************
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg & psel & penable;
  assign irq     = irq_reg;

  always_comb begin
    rd_mux = `TXSA_RST_ZERO32;
    mapped = 1'b1;
    unique case (paddr)
      `TXSA_OFS_RX_CLEAR:   rd_mux[`TXSA_BIT_CLEAR] = rx_clr_reg;
      `TXSA_OFS_TX_CLEAR:   rd_mux[`TXSA_BIT_CLEAR] = tx_clr_reg;
      `TXSA_OFS_RX_GOOD_LO: rd_mux = rx_good_reg[`TXSA_CNT_LO_W-1:0];                  // R11
      `TXSA_OFS_RX_GOOD_HI: rd_mux[3:0] = rx_good_reg[`TXSA_CNT_W-1:`TXSA_CNT_LO_W];     // R11
      `TXSA_OFS_TX_GOOD_LO: rd_mux = tx_good_reg[`TXSA_CNT_LO_W-1:0];                  // R11
      `TXSA_OFS_TX_GOOD_HI: rd_mux[3:0] = tx_good_reg[`TXSA_CNT_W-1:`TXSA_CNT_LO_W];     // R11
      `TXSA_OFS_INS_CTRL:   rd_mux[`TXSA_BIT_ENABLE] = ins_en_reg;                      // R1
      `TXSA_OFS_ADDR_LOW:   rd_mux = addr_low_reg;                                      // R4
      `TXSA_OFS_ADDR_HIGH:  rd_mux[`TXSA_ADDR_HIGH_W-1:0] = addr_high_reg;              // R4
      `TXSA_OFS_LEN_LIMIT:  rd_mux[`TXSA_LEN_W-1:0] = len_limit_reg;                    // R5
      `TXSA_OFS_IRQ_STATUS: rd_mux[`TXSA_IRQ_W-1:0] = irq_stat_reg;
      `TXSA_OFS_IRQ_MASK:   rd_mux[`TXSA_IRQ_W-1:0] = irq_mask_reg;
      default:              mapped = 1'b0;
    endcase
  end

  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      rdata_next = pwrite ? `TXSA_RST_ZERO32 : rd_mux;
      err_next   = ~mapped;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_comb begin
    ins_en_next    = ins_en_reg;
    addr_low_next  = addr_low_reg;
    addr_high_next = addr_high_reg;
    len_limit_next = len_limit_reg;
    irq_mask_next  = irq_mask_reg;
    // a pending clear is a one-cycle request; it drops after acting
    rx_clr_next    = 1'b0;                                                             // R12
    tx_clr_next    = 1'b0;                                                             // R12
    if (wr_acc) begin
      unique case (paddr)
        `TXSA_OFS_INS_CTRL:  ins_en_next    = pwdata[`TXSA_BIT_ENABLE];                 // R1
        `TXSA_OFS_ADDR_LOW:  addr_low_next  = pwdata;                                   // R4
        `TXSA_OFS_ADDR_HIGH: addr_high_next = pwdata[`TXSA_ADDR_HIGH_W-1:0];            // R4
        `TXSA_OFS_LEN_LIMIT: len_limit_next = pwdata[`TXSA_LEN_W-1:0];                  // R5
        `TXSA_OFS_RX_CLEAR:  rx_clr_next    = pwdata[`TXSA_BIT_CLEAR];                  // R8
        `TXSA_OFS_TX_CLEAR:  tx_clr_next    = pwdata[`TXSA_BIT_CLEAR];                  // R9
        `TXSA_OFS_IRQ_MASK:  irq_mask_next  = pwdata[`TXSA_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // transmit frame length and per-frame status
  // ****************************************************************
  assign out_fire   = tx_out_valid & tx_out_ready;
  assign beat_bytes = tx_out_beat.eop ? (`TXSA_BEAT_BYTES - {14'h0000, tx_out_beat.empty})
                                      : `TXSA_BEAT_BYTES;

  // measured after the pipe stage; the limit only tags, never stalls the frame
  always_comb begin
    frame_len = (tx_out_beat.sop ? 17'h00000 : len_acc_reg) + beat_bytes;
    if (!tx_out_beat.sop && len_acc_reg[16]) begin
      frame_len = len_acc_reg;  // saturate past 64 KiB
    end
    oversize = frame_len > {1'b0, len_limit_reg};                                      // R6
  end

  always_comb begin
    len_acc_next = len_acc_reg;
    status_next  = '0;
    if (out_fire) begin
      len_acc_next = frame_len;
      if (tx_out_beat.eop) begin                                                       // R7
        status_next.valid                    = 1'b1;
        status_next.error[`TXSA_ERR_CLIENT]   = tx_out_beat.error;
        status_next.error[`TXSA_ERR_OVERSIZE] = oversize;                              // R6
      end
    end
  end
  assign tx_frame_status_error = status_reg;

  // ****************************************************************
  // statistics counters
  // ****************************************************************
  always_comb begin
    rx_good_next = rx_good_reg;
    tx_good_next = tx_good_reg;
    if (rx_status_valid && !rx_status_error) begin                                     // R10
      rx_good_next = rx_good_reg + 36'h0_0000_0001;
    end
    // oversized frames are errored, so they stay out of the good count
    if (status_reg.valid && status_reg.error == 2'h0) begin                             // R10
      tx_good_next = tx_good_reg + 36'h0_0000_0001;
    end
    // clear wins over a coincident count; that frame is dropped from stats
    if (rx_clr_reg) begin                                                              // R8
      rx_good_next = '0;
    end
    if (tx_clr_reg) begin                                                              // R9
      tx_good_next = '0;
    end
  end

  // ****************************************************************
  // interrupts: sticky, cleared by reading, set beats clear
  // ****************************************************************
  always_comb begin
    irq_event                        = '0;
    irq_event[`TXSA_IRQ_TX_DONE]     = status_reg.valid;
    irq_event[`TXSA_IRQ_TX_OVERSIZE] = status_reg.valid & status_reg.error[`TXSA_ERR_OVERSIZE];
    irq_event[`TXSA_IRQ_RX_ERROR]    = rx_status_valid & rx_status_error;
    irq_stat_next = irq_stat_reg;
    if (rd_acc && paddr == `TXSA_OFS_IRQ_STATUS) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | irq_event;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // insertion enable; reset leaves every frame untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_en_reg    <= 1'b0;                                                           // R2
    end else begin
      ins_en_reg    <= ins_en_next;
    end
  end

  // programmed source address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg  <= `TXSA_RST_ZERO32;
      addr_high_reg <= '0;
    end else begin
      addr_low_reg  <= addr_low_next;
      addr_high_reg <= addr_high_next;
    end
  end

  // length limit; reset is the standard maximum frame size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_limit_reg <= `TXSA_RST_LEN_LIMIT;                                            // R5
    end else begin
      len_limit_reg <= len_limit_next;
    end
  end

  // receive statistics; the clear request lives one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clr_reg    <= 1'b0;
      rx_good_reg   <= '0;
    end else begin
      rx_clr_reg    <= rx_clr_next;
      rx_good_reg   <= rx_good_next;
    end
  end

  // transmit statistics
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clr_reg    <= 1'b0;
      tx_good_reg   <= '0;
    end else begin
      tx_clr_reg    <= tx_clr_next;
      tx_good_reg   <= tx_good_next;
    end
  end

  // running frame length and the per-frame status pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_acc_reg   <= '0;
      status_reg    <= '0;
    end else begin
      len_acc_reg   <= len_acc_next;
      status_reg    <= status_next;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg  <= '0;
    end else begin
      irq_mask_reg  <= irq_mask_next;
    end
  end

  // sticky interrupt status and the registered request line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg  <= '0;
      irq_reg       <= 1'b0;
    end else begin
      irq_stat_reg  <= irq_stat_next;
      irq_reg       <= irq_next;
    end
  end

  // apb read data and error, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg     <= `TXSA_RST_ZERO32;
      err_reg       <= 1'b0;
    end else begin
      rdata_reg     <= rdata_next;
      err_reg       <= err_next;
    end
  end

endmodule : txsa_top
`default_nettype wire

//--- txsa_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "txsa_consts.svh"
module txsa_top_test;
  import txsa_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, tx_in_ready, tx_out_valid, tx_out_ready, irq;
  logic tx_in_valid = 1'b0, rx_status_valid = 1'b0, rx_status_error = 1'b0, stall = 1'b0, ins_on = 1'b0;
  txsa_beat_type tx_in_beat = '0, tx_out_beat, exp_q [$];
  txsa_status_type tx_frame_status_error;
  logic [47:0] ins_addr = 48'h0;
  logic [1:0] last_err = 2'h0;
  int n_mismatch = 0, check_count = 0, n_stat = 0;
  txsa_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_in_beat, .tx_in_valid, .tx_in_ready, .tx_out_beat, .tx_out_valid, .tx_out_ready,
    .tx_frame_status_error, .rx_status_valid, .rx_status_error, .irq);
  txsa_partner sink_u (.pclk, .stall, .beat(tx_out_beat), .valid(tx_out_valid), .ready(tx_out_ready));
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (tx_frame_status_error.valid === 1'b1) begin
    n_stat <= n_stat + 1;
    last_err <= tx_frame_status_error.error;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic send(input int n, input logic [7:0] s);
    txsa_beat_type b, e;
    logic rdy;
    for (int i = 0; i < n; i += 8) begin
      b = '0;
      for (int j = 0; j < 8; j++) b.data[63-8*j -: 8] = s + 8'(i + j);
      b.sop = (i == 0);
      b.eop = (i + 8 >= n);
      if (b.eop) b.empty = 3'(i + 8 - n);
      e = b;
      for (int j = 0; j < 8; j++) if (ins_on && i + j >= 6 && i + j < 12) e.data[63-8*j -: 8] = ins_addr[95-8*(i+j) -: 8];
      exp_q.push_back(e);
      tx_in_beat <= b;
      tx_in_valid <= 1'b1;
      do begin @(negedge pclk); rdy = tx_in_ready; @(posedge pclk); end while (rdy !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    @(posedge pclk);
  endtask : send
  task automatic drain(input int stat_goal);
    for (int k = 0; k < 300 && (sink_u.got.size() < exp_q.size() || n_stat < stat_goal); k++) @(posedge pclk);
    chk("beat count", sink_u.got.size(), exp_q.size());
    while (exp_q.size() > 0 && sink_u.got.size() > 0) chk("beat", sink_u.got.pop_front(), exp_q.pop_front());
    chk("status count", n_stat, stat_goal);
    sink_u.got.delete();
    exp_q.delete();
  endtask : drain
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [15:0] a [8] = '{`TXSA_OFS_RX_CLEAR, `TXSA_OFS_RX_GOOD_LO, `TXSA_OFS_RX_GOOD_HI, `TXSA_OFS_INS_CTRL,
      `TXSA_OFS_ADDR_LOW, `TXSA_OFS_ADDR_HIGH, `TXSA_OFS_TX_CLEAR, `TXSA_OFS_TX_GOOD_LO};
    foreach (a[k]) begin
      apb(1'b0, a[k], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, `TXSA_OFS_LEN_LIMIT, 32'h0);
    chk("limit reset", rd[15:0], 16'h05ee);
    apb(1'b0, 16'h6000, 32'h0);
    chk("unmapped error", err_seen, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_insert;
    stall <= 1'b1;
    apb(1'b1, `TXSA_OFS_ADDR_LOW, 32'h2317_4acb);
    apb(1'b1, `TXSA_OFS_ADDR_HIGH, 32'h0000_001c);
    apb(1'b1, `TXSA_OFS_INS_CTRL, 32'hffff_fffe);
    send(24, 8'h10);
    drain(1);
    apb(1'b0, `TXSA_OFS_ADDR_HIGH, 32'h0);
    chk("high half", rd[15:0], 16'h001c);
    apb(1'b1, `TXSA_OFS_INS_CTRL, 32'h0000_0001);
    ins_on = 1'b1;
    ins_addr = 48'h001c_2317_4acb;
    stall <= 1'b0;
    send(32, 8'h40);
    send(12, 8'h80);
    drain(3);
    apb(1'b1, `TXSA_OFS_INS_CTRL, 32'h0);
    ins_on = 1'b0;
    $display("test insertion done");
  endtask : t_insert
  task automatic t_length;
    apb(1'b0, `TXSA_OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, `TXSA_OFS_LEN_LIMIT, 32'h1234_0010);
    apb(1'b0, `TXSA_OFS_LEN_LIMIT, 32'h0);
    chk("limit", rd[15:0], 16'h0010);
    send(16, 8'h20);
    drain(4);
    chk("equal length status", last_err, 2'b00);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, `TXSA_OFS_IRQ_MASK, 32'h0000_0002);
    stall <= 1'b1;
    send(17, 8'h30);
    drain(5);
    repeat (2) @(posedge pclk);
    chk("oversize status", last_err, 2'b10);
    chk("irq raised", irq, 1'b1);
    apb(1'b0, `TXSA_OFS_IRQ_STATUS, 32'h0);
    chk("irq status", rd, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    $display("test length done");
  endtask : t_length
  task automatic t_count;
    logic e [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    foreach (e[k]) begin
      rx_status_valid <= 1'b1;
      rx_status_error <= e[k];
      @(posedge pclk);
    end
    rx_status_valid <= 1'b0;
    apb(1'b0, `TXSA_OFS_RX_GOOD_LO, 32'h0);
    chk("rx good", rd, 32'h3);
    apb(1'b0, `TXSA_OFS_TX_GOOD_LO, 32'h0);
    chk("tx good", rd, 32'h4);
    apb(1'b0, `TXSA_OFS_TX_GOOD_HI, 32'h0);
    chk("tx good high", rd, 32'h0);
    apb(1'b1, `TXSA_OFS_TX_CLEAR, 32'h1);
    repeat (2) @(posedge pclk);
    apb(1'b0, `TXSA_OFS_TX_CLEAR, 32'h0);
    chk("tx clear bit", rd, 32'h0);
    apb(1'b0, `TXSA_OFS_TX_GOOD_LO, 32'h0);
    chk("tx cleared", rd, 32'h0);
    apb(1'b0, `TXSA_OFS_RX_GOOD_LO, 32'h0);
    chk("rx kept", rd, 32'h3);
    apb(1'b1, `TXSA_OFS_RX_CLEAR, 32'h1);
    repeat (2) @(posedge pclk);
    apb(1'b0, `TXSA_OFS_RX_GOOD_LO, 32'h0);
    chk("rx cleared", rd, 32'h0);
    $display("test counters done");
  endtask : t_count
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_insert;
    t_length;
    t_count;
    test_done;
  end
  // the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end
endmodule : txsa_top_test
bind txsa_top txsa_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .tx_in_beat, .tx_in_valid, .tx_in_ready, .tx_out_beat, .tx_out_valid, .tx_out_ready,
  .tx_frame_status_error, .rx_status_valid, .rx_status_error, .irq);
`default_nettype wire
